// File: src/gripper_regif.sv
// Gripper command interpreter: parses request frames, keeps command words, answers status.
// Assumes frames arrive whole on the RX byte stream and gripper status comes from logic on MCLK.
`timescale 1ns/1ns
module gripper_regif #(
    parameter logic [7:0] UNIT_ID = gripper_pkg::UNIT_ID_DEFAULT
) (
    input  wire logic       MCLK,
    input  wire logic       SRST,
    input  wire logic       RX_VALID,
    input  wire logic [7:0] RX_DATA,
    input  wire logic       RX_LAST,
    output logic            RX_READY,
    output logic            TX_VALID,
    output logic [7:0]      TX_DATA,
    output logic            TX_LAST,
    input  wire logic       TX_READY,
    output logic [7:0]      ACTION_AND_OPTIONS_WORD,
    output logic            ACTIVATE_REQUEST_BIT,
    output logic            GOTO_REQUEST_BIT,
    output logic [7:0]      GRIPPER_OPTIONS,
    output logic [7:0]      GRIPPER_OPTIONS2,
    output logic [7:0]      TARGET_POSITION_REQUEST,
    output logic [7:0]      SPEED_REQUEST,
    output logic [7:0]      FORCE_REQUEST,
    output logic            COMMAND_STROBE,
    input  wire logic [1:0] ACTIVATION_STATE,
    input  wire logic [1:0] OBJECT_DETECT_STATUS,
    input  wire logic [7:0] FAULT_STATUS,
    input  wire logic [7:0] FINGER_POSITION,
    input  wire logic [7:0] FINGER_CURRENT
);

    typedef struct packed {
        gripper_pkg::rx_frame_t rx_bytes;
        logic [4:0]             count;
        logic                   ovf;
        logic [2:0][15:0]       cmd;
        logic                   cmd_strobe;
        logic [1:0]             sta;
        logic [1:0]             obj;
        logic [7:0]             fault;
        logic [7:0]             pos;
        logic [7:0]             cur;
    } state_s;

    state_s                 st;
    state_s                 next_st;
    logic                   tx_busy;
    logic                   load;
    gripper_pkg::tx_frame_t tf;
    logic [3:0]             tl;
    logic                   rx_fire;
    logic [2:0][15:0]       word;

    function automatic logic [7:0] status_byte(input logic act, input logic gto,
                                               input logic [1:0] sta, input logic [1:0] obj);
        logic [7:0] b;
        b = 8'h00;
        b[gripper_pkg::ACT_BIT]        = act;
        b[gripper_pkg::GTO_BIT]        = gto;
        b[gripper_pkg::STA_LSB +: 2]   = sta;
        b[gripper_pkg::OBJ_LSB +: 2]   = obj;
        return b;
    endfunction

    assign rx_fire  = RX_VALID && RX_READY;
    assign RX_READY = !tx_busy;

    // ==========================================
    // Input registers as seen by the client
    always_comb begin
        word[gripper_pkg::REG_STATUS] = {status_byte(st.cmd[0][8+gripper_pkg::ACT_BIT],
                                                     st.cmd[0][8+gripper_pkg::GTO_BIT],
                                                     st.sta, st.obj),
                                         gripper_pkg::RESERVED_BYTE};
        word[gripper_pkg::REG_FAULT]  = {st.fault, st.cmd[1][7:0]};
        word[gripper_pkg::REG_POS]    = {st.pos, st.cur};
    end

    // ==========================================
    // Frame collector and interpreter
    gripper_pkg::rx_frame_t f;
    logic [4:0]             n;
    logic [15:0]            len;
    logic [15:0]            start;
    logic [15:0]            qty;
    logic                   hdr_ok;
    logic                   rng_ok;
    logic [1:0]             ri;

    always_comb begin
        next_st            = st;
        next_st.cmd_strobe = 1'b0;
        f      = st.rx_bytes;
        n      = st.count + 5'h1;
        load   = 1'b0;
        tf     = '0;
        tl     = 4'h0;
        hdr_ok = 1'b0;
        rng_ok = 1'b0;
        ri     = 2'h0;
        len    = 16'h0000;
        start  = 16'h0000;
        qty    = 16'h0000;
        // Status inputs other than the position are sampled every cycle so the reply is one consistent snapshot
        next_st.sta   = ACTIVATION_STATE;
        next_st.obj   = OBJECT_DETECT_STATUS;
        next_st.fault = FAULT_STATUS;
        next_st.cur   = FINGER_CURRENT;
        // Contact freezes the position so the client can size the held object
        if (OBJECT_DETECT_STATUS != gripper_pkg::OBJ_STOP_OPN &&
            OBJECT_DETECT_STATUS != gripper_pkg::OBJ_STOP_CLS) begin
            next_st.pos = FINGER_POSITION;
        end
        if (rx_fire) begin
            if (st.count < 5'(gripper_pkg::RX_MAX)) begin
                f[st.count]      = RX_DATA;
                next_st.rx_bytes = f;
                next_st.count    = n;
            end else begin
                next_st.ovf = 1'b1;
            end
            if (RX_LAST) begin
                next_st.count = 5'h0;
                next_st.ovf   = 1'b0;
                len    = {f[gripper_pkg::POS_LEN], f[gripper_pkg::POS_LEN+1]};
                start  = {f[gripper_pkg::POS_START], f[gripper_pkg::POS_START+1]};
                qty    = {f[gripper_pkg::POS_QTY], f[gripper_pkg::POS_QTY+1]};
                // Overlong frames are dropped rather than half interpreted
                hdr_ok = !st.ovf && st.count < 5'(gripper_pkg::RX_MAX) &&
                         {f[gripper_pkg::POS_PROTO], f[gripper_pkg::POS_PROTO+1]} == gripper_pkg::PROTO_ID &&
                         f[gripper_pkg::POS_UNIT] == UNIT_ID &&
                         n >= 5'(gripper_pkg::POS_BC) &&
                         len == 16'(n) - 16'(gripper_pkg::MBAP_TAIL);
                rng_ok = qty != 16'h0 && qty <= 16'(gripper_pkg::NUM_REGS) &&
                         // Widened sum, so a start near the top of the address space cannot wrap into range
                         17'(start) + 17'(qty) <= 17'(gripper_pkg::NUM_REGS);
                tf[gripper_pkg::POS_TID]   = f[gripper_pkg::POS_TID];
                tf[gripper_pkg::POS_TID+1] = f[gripper_pkg::POS_TID+1];
                tf[gripper_pkg::POS_UNIT]  = f[gripper_pkg::POS_UNIT];
                tf[gripper_pkg::POS_FC]    = f[gripper_pkg::POS_FC];
                if (hdr_ok && rng_ok && f[gripper_pkg::POS_FC] == gripper_pkg::FC_READ_INPUT &&
                    len == gripper_pkg::READ_REQ_LEN) begin
                    load = 1'b1;
                    tf[gripper_pkg::POS_LEN+1] = 8'(gripper_pkg::READ_LEN_BASE + 16'(qty[1:0]) * 16'h2);
                    tf[gripper_pkg::POS_RBC]   = 8'({qty[1:0], 1'b0});
                    for (int k = 0; k < gripper_pkg::NUM_REGS; k++) begin
                        if (k < int'(qty)) begin
                            ri = 2'(start[1:0] + 2'(k));
                            tf[gripper_pkg::POS_RDATA+2*k]   = word[ri][15:8];
                            tf[gripper_pkg::POS_RDATA+2*k+1] = word[ri][7:0];
                        end
                    end
                    tl = 4'(gripper_pkg::POS_RDATA + 2 * int'(qty));
                end else if (hdr_ok && rng_ok && f[gripper_pkg::POS_FC] == gripper_pkg::FC_WRITE_MULTI &&
                             f[gripper_pkg::POS_BC] == 8'({qty[1:0], 1'b0}) &&
                             len == gripper_pkg::WRITE_LEN_BASE + 16'(qty[1:0]) * 16'h2) begin
                    load               = 1'b1;
                    next_st.cmd_strobe = 1'b1;
                    for (int r = 0; r < gripper_pkg::NUM_REGS; r++) begin
                        if (r >= int'(start) && r < int'(start) + int'(qty)) begin
                            next_st.cmd[r] = {f[gripper_pkg::POS_WDATA + 2*(r-int'(start))],
                                              f[gripper_pkg::POS_WDATA + 2*(r-int'(start)) + 1]};
                        end
                    end
                    tf[gripper_pkg::POS_LEN+1]  = gripper_pkg::WRITE_RESP_LEN[7:0];
                    tf[gripper_pkg::POS_START]   = f[gripper_pkg::POS_START];
                    tf[gripper_pkg::POS_START+1] = f[gripper_pkg::POS_START+1];
                    tf[gripper_pkg::POS_QTY]     = f[gripper_pkg::POS_QTY];
                    tf[gripper_pkg::POS_QTY+1]   = f[gripper_pkg::POS_QTY+1];
                    tl = 4'(gripper_pkg::POS_BC);
                end
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    resp_shifter u_shift (
        .clk   (MCLK),
        .srst  (SRST),
        .load  (load),
        .frame (tf),
        .len   (tl),
        .ready (TX_READY),
        .valid (TX_VALID),
        .data  (TX_DATA),
        .last  (TX_LAST),
        .busy  (tx_busy)
    );

    assign ACTION_AND_OPTIONS_WORD          = st.cmd[gripper_pkg::REG_ACTION][15:8];
    assign ACTIVATE_REQUEST_BIT    = st.cmd[gripper_pkg::REG_ACTION][8+gripper_pkg::ACT_BIT];
    assign GOTO_REQUEST_BIT        = st.cmd[gripper_pkg::REG_ACTION][8+gripper_pkg::GTO_BIT];
    assign GRIPPER_OPTIONS         = st.cmd[gripper_pkg::REG_ACTION][7:0];
    assign GRIPPER_OPTIONS2        = st.cmd[gripper_pkg::REG_TARGET][15:8];
    assign TARGET_POSITION_REQUEST = st.cmd[gripper_pkg::REG_TARGET][7:0];
    assign SPEED_REQUEST           = st.cmd[gripper_pkg::REG_SPEED][15:8];
    assign FORCE_REQUEST           = st.cmd[gripper_pkg::REG_SPEED][7:0];
    assign COMMAND_STROBE          = st.cmd_strobe;

    // ==========================================
    // Checks
    write_reply_a: assert property (@(posedge MCLK) disable iff (SRST)
        load && next_st.cmd_strobe |-> tf[5] == 8'h06 && tf[4] == 8'h00 && tl == 4'hc)
        else $error("write reply length wrong");
    read_reply_a: assert property (@(posedge MCLK) disable iff (SRST)
        load && !next_st.cmd_strobe && qty == 16'h3 |-> tf[5] == 8'h09 && tf[8] == 8'h06 && tl == 4'hf)
        else $error("read reply length wrong");
    tid_echo_a: assert property (@(posedge MCLK) disable iff (SRST)
        load |-> tf[0] == f[0] && tf[1] == f[1] ##1 TX_VALID && TX_DATA == $past(f[0]))
        else $error("transaction id not echoed");
    proto_zero_a: assert property (@(posedge MCLK) disable iff (SRST)
        load |-> tf[2] == 8'h00 && tf[3] == 8'h00)
        else $error("protocol id not zero");
    status_low_a: assert property (@(posedge MCLK) disable iff (SRST)
        word[0][7:0] == 8'h00 && word[0][8] == ACTIVATE_REQUEST_BIT && word[0][11] == GOTO_REQUEST_BIT)
        else $error("status word layout wrong");
    moving_code_a: assert property (@(posedge MCLK) disable iff (SRST)
        ACTION_AND_OPTIONS_WORD == 8'h09 && st.sta == 2'h3 && st.obj == 2'h0 |-> word[0][15:8] == 8'h39)
        else $error("moving status byte wrong");
    contact_code_a: assert property (@(posedge MCLK) disable iff (SRST)
        ACTION_AND_OPTIONS_WORD == 8'h09 && st.sta == 2'h3 && st.obj == 2'h2 |-> word[0][15:8] == 8'hb9)
        else $error("contact status byte wrong");
    goal_code_a: assert property (@(posedge MCLK) disable iff (SRST)
        ACTION_AND_OPTIONS_WORD == 8'h09 && st.sta == 2'h3 && st.obj == 2'h3 |-> word[0][15:8] == 8'hf9)
        else $error("at goal status byte wrong");
    target_echo_a: assert property (@(posedge MCLK) disable iff (SRST)
        COMMAND_STROBE |-> word[1][7:0] == TARGET_POSITION_REQUEST && word[1][15:8] == st.fault)
        else $error("position echo wrong");
    current_track_a: assert property (@(posedge MCLK) disable iff (SRST)
        1'b1 ##1 1'b1 |-> word[2][7:0] == $past(FINGER_CURRENT))
        else $error("current byte not tracking");
    pos_hold_a: assert property (@(posedge MCLK) disable iff (SRST)
        OBJECT_DETECT_STATUS == 2'h2 |=> $stable(word[2][15:8]))
        else $error("position not held on contact");
    unit_filter_a: assert property (@(posedge MCLK) disable iff (SRST)
        rx_fire && RX_LAST && f[6] != UNIT_ID |-> !load ##1 !COMMAND_STROBE)
        else $error("foreign unit answered");
    strobe_reply_a: assert property (@(posedge MCLK) disable iff (SRST)
        COMMAND_STROBE |-> TX_VALID && !RX_READY)
        else $error("write taken without reply");
    write_seen_c: cover property (@(posedge MCLK) disable iff (SRST) COMMAND_STROBE && ACTION_AND_OPTIONS_WORD == 8'h09);
    read_seen_c: cover property (@(posedge MCLK) disable iff (SRST) load && !next_st.cmd_strobe);
    contact_c: cover property (@(posedge MCLK) disable iff (SRST) word[0][15:8] == 8'hb9);
    dropped_c: cover property (@(posedge MCLK) disable iff (SRST) rx_fire && RX_LAST && !load);

endmodule

// File: src/gripper_pkg.sv
// Shared constants and types of the gripper command interpreter.
// Assumes a byte stream of whole application frames, header first.
package gripper_pkg;

    // ==========================================
    // Frame header and function codes
    localparam logic [15:0] PROTO_ID        = 16'h0000;
    localparam logic [7:0]  FC_WRITE_MULTI  = 8'h10;
    localparam logic [7:0]  FC_READ_INPUT   = 8'h04;
    localparam logic [15:0] WRITE_RESP_LEN  = 16'h0006;
    localparam logic [15:0] READ_REQ_LEN    = 16'h0006;
    localparam logic [15:0] WRITE_LEN_BASE  = 16'h0007;
    localparam logic [15:0] READ_LEN_BASE   = 16'h0003;
    localparam logic [7:0]  UNIT_ID_DEFAULT = 8'h02;

    // ==========================================
    // Byte positions inside a frame
    localparam int POS_TID   = 0;
    localparam int POS_PROTO = 2;
    localparam int POS_LEN   = 4;
    localparam int POS_UNIT  = 6;
    localparam int POS_FC    = 7;
    localparam int POS_START = 8;
    localparam int POS_QTY   = 10;
    localparam int POS_BC    = 12;
    localparam int POS_WDATA = 13;
    localparam int POS_RBC   = 8;
    localparam int POS_RDATA = 9;
    localparam int MBAP_TAIL = 6;
    localparam int RX_MAX    = 19;
    localparam int TX_MAX    = 15;
    localparam int NUM_REGS  = 3;

    // ==========================================
    // Register offsets (read side and write side share numbers)
    localparam int REG_STATUS = 0;
    localparam int REG_FAULT  = 1;
    localparam int REG_POS    = 2;
    localparam int REG_ACTION = 0;
    localparam int REG_TARGET = 1;
    localparam int REG_SPEED  = 2;

    // ==========================================
    // Status and action byte fields
    localparam int          ACT_BIT      = 0;
    localparam int          GTO_BIT      = 3;
    localparam int          STA_LSB      = 4;
    localparam int          OBJ_LSB      = 6;
    localparam logic [1:0]  STA_BUSY     = 2'h1;
    localparam logic [1:0]  STA_DONE     = 2'h3;
    localparam logic [1:0]  OBJ_MOVING   = 2'h0;
    localparam logic [1:0]  OBJ_STOP_OPN = 2'h1;
    localparam logic [1:0]  OBJ_STOP_CLS = 2'h2;
    localparam logic [1:0]  OBJ_AT_GOAL  = 2'h3;
    localparam logic [7:0]  RESERVED_BYTE = 8'h00;
    localparam int          CURRENT_MA_PER_COUNT = 10;
    localparam logic [15:0] CMD_RESET    = 16'h0000;

    typedef logic [RX_MAX-1:0][7:0] rx_frame_t;
    typedef logic [TX_MAX-1:0][7:0] tx_frame_t;

endpackage

// File: src/resp_shifter.sv
// Response shifter: takes a whole reply frame at once and sends it byte by byte.
// Assumes the sink honours valid/ready and that load comes only while idle.
`timescale 1ns/1ns
module resp_shifter (
    input  wire logic                  clk,
    input  wire logic                  srst,
    input  wire logic                  load,
    input  wire gripper_pkg::tx_frame_t frame,
    input  wire logic [3:0]            len,
    input  wire logic                  ready,
    output logic                       valid,
    output logic [7:0]                 data,
    output logic                       last,
    output logic                       busy
);

    typedef struct packed {
        gripper_pkg::tx_frame_t bytes;
        logic [3:0]             left;
    } shift_s;

    shift_s st;
    shift_s next_st;

    // ==========================================
    // Shift register
    always_comb begin
        next_st = st;
        if (load) begin
            next_st.bytes = frame;
            next_st.left  = len;
        end else if (st.left != 4'h0 && ready) begin
            next_st.bytes = {8'h00, st.bytes[gripper_pkg::TX_MAX-1:1]};
            next_st.left  = st.left - 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign busy  = (st.left != 4'h0);
    assign valid = busy;
    assign data  = st.bytes[0];
    assign last  = (st.left == 4'h1);

endmodule

// File: verif/modbus_client.sv
// Robot controller model: sends whole request frames and drains the replies.
// Assumes a byte stream that is held until RX_READY is seen at a rising edge.
`timescale 1ns/1ns
module modbus_client (
    input  wire logic       mclk,
    input  wire logic       rx_ready,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_last,
    output logic            tx_ready
);
    typedef logic [7:0] byte_q_t[$];
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        rx_last  = 1'b0;
        tx_ready = 1'b0;
    end
    // ==========================================
    // Request side
    task automatic send(input byte_q_t f);
        foreach (f[i]) begin
            @(negedge mclk);
            rx_valid = 1'b1;
            rx_data  = f[i];
            rx_last  = (i == f.size() - 1);
            do @(posedge mclk); while (rx_ready !== 1'b1);
        end
        @(negedge mclk);
        rx_valid = 1'b0;
        rx_last  = 1'b0;
        // Inverted idle byte, so a stale value can never pass for data
        rx_data  = ~rx_data;
    endtask
    // ==========================================
    // Reply side: a slow client takes only one cycle in three
    task automatic get(output byte_q_t r, input logic slow);
        int   n;
        logic done;
        n    = 0;
        done = 1'b0;
        r    = {};
        while (!done) begin
            @(negedge mclk);
            tx_ready = !slow || (n % 3 == 0);
            n++;
            @(posedge mclk);
            if (tx_valid === 1'b1 && tx_ready) begin
                r.push_back(tx_data);
                done = (tx_last === 1'b1);
            end
        end
        @(negedge mclk);
        tx_ready = 1'b0;
    endtask
endmodule

// File: verif/tb.sv
// Self-checking bench of the gripper command interpreter.
// Assumes the client model owns the request and reply streams.
`timescale 1ns/1ns
module tb;
    typedef logic [7:0] bq_t[$];
    localparam logic [7:0] UID = gripper_pkg::UNIT_ID_DEFAULT;
    logic        mclk, srst, rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
    logic        act_bit, gto_bit, strobe;
    logic [7:0]  rx_data, tx_data, action, opts, opts2, target, speed, force_req;
    logic [7:0]  fault, fpos, fcur, mpos;
    logic [1:0]  sta, obj;
    logic [15:0] hold[3];
    logic [31:0] seed, r;
    int          num_errors, comparisons, strobes, exp_strobes, cycles, s, n;

    gripper_regif dut (.MCLK(mclk), .SRST(srst), .RX_VALID(rx_valid), .RX_DATA(rx_data),
        .RX_LAST(rx_last), .RX_READY(rx_ready), .TX_VALID(tx_valid), .TX_DATA(tx_data),
        .TX_LAST(tx_last), .TX_READY(tx_ready), .ACTION_AND_OPTIONS_WORD(action),
        .ACTIVATE_REQUEST_BIT(act_bit), .GOTO_REQUEST_BIT(gto_bit), .GRIPPER_OPTIONS(opts),
        .GRIPPER_OPTIONS2(opts2), .TARGET_POSITION_REQUEST(target), .SPEED_REQUEST(speed),
        .FORCE_REQUEST(force_req), .COMMAND_STROBE(strobe), .ACTIVATION_STATE(sta),
        .OBJECT_DETECT_STATUS(obj), .FAULT_STATUS(fault), .FINGER_POSITION(fpos),
        .FINGER_CURRENT(fcur));
    modbus_client cl (.mclk(mclk), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
        .tx_ready(tx_ready));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // ==========================================
    // Checking helpers
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (strobe === 1'b1)
            strobes++;
        // Whole run needs about a thousand cycles
        if (cycles == 20000) begin
            num_errors++;
            print_verdict();
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // ==========================================
    // Reference model of the register words
    function automatic logic [15:0] mw(int i);
        if (i == 0)
            return {obj, sta, hold[0][11], 2'b00, hold[0][8], 8'h00};
        if (i == 1)
            return {fault, hold[1][7:0]};
        return {mpos, fcur};
    endfunction
    function automatic bq_t hdr(logic [15:0] tid, logic [15:0] pid, int len, logic [7:0] u, logic [7:0] fc);
        return {tid[15:8], tid[7:0], pid[15:8], pid[7:0], 8'h00, 8'(len), u, fc};
    endfunction
    task automatic cmp(input bq_t e, input bq_t g);
        chk("reply_len", 16'(e.size()), 16'(g.size()));
        foreach (e[i])
            if (i < g.size())
                chk("reply_byte", e[i], g[i]);
    endtask
    // Position is applied after the object field, so a stop freezes the old one
    task automatic ss(logic [1:0] a, logic [1:0] o, logic [7:0] f, logic [7:0] p, logic [7:0] c);
        @(negedge mclk);
        {sta, obj, fault, fcur} = {a, o, f, c};
        repeat (2) @(negedge mclk);
        fpos = p;
        if (o != 2'h1 && o != 2'h2)
            mpos = p;
        repeat (2) @(negedge mclk);
    endtask
    task automatic wr(int s, int n, logic [15:0] a, b, c, logic slow, logic [7:0] u = UID,
                      logic [15:0] pid = 16'h0000);
        logic [15:0] v[3];
        logic [15:0] tid;
        bq_t         f, e, g;
        v   = '{a, b, c};
        tid = 16'(xs());
        f   = hdr(tid, pid, 7 + 2 * n, u, 8'h10);
        f   = {f, 8'h00, 8'(s), 8'h00, 8'(n), 8'(2 * n)};
        for (int i = 0; i < n; i++)
            f = {f, v[i][15:8], v[i][7:0]};
        cl.send(f);
        if (u != UID || pid != 16'h0000) begin
            repeat (20) @(negedge mclk);
            chk("tx_idle", 16'h0001, {14'h0000, tx_valid, rx_ready});
        end else begin
            for (int i = 0; i < n; i++)
                hold[s + i] = v[i];
            exp_strobes++;
            e = hdr(tid, 16'h0000, 6, UID, 8'h10);
            e = {e, 8'h00, 8'(s), 8'h00, 8'(n)};
            cl.get(g, slow);
            cmp(e, g);
        end
        chk("strobes", 16'(exp_strobes), 16'(strobes));
        chk("action_word", hold[0], {action, opts});
        chk("target_word", hold[1], {opts2, target});
        chk("speed_word", hold[2], {speed, force_req});
        chk("request_bits", {14'h0000, hold[0][11], hold[0][8]}, {14'h0000, gto_bit, act_bit});
    endtask
    task automatic rd(int s, int n, logic slow);
        logic [15:0] tid, w;
        bq_t         f, e, g;
        tid = 16'(xs());
        f   = hdr(tid, 16'h0000, 6, UID, 8'h04);
        f   = {f, 8'h00, 8'(s), 8'h00, 8'(n)};
        cl.send(f);
        e = hdr(tid, 16'h0000, 3 + 2 * n, UID, 8'h04);
        e.push_back(8'(2 * n));
        for (int i = 0; i < n; i++) begin
            w = mw(s + i);
            e = {e, w[15:8], w[7:0]};
        end
        cl.get(g, slow);
        cmp(e, g);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        {srst, sta, obj, fault, fpos, fcur, mpos} = {1'b1, 36'h0};
        seed = 32'h00016c30;
        hold = '{16'h0000, 16'h0000, 16'h0000};
        repeat (2) @(negedge mclk);
        srst = 1'b0;
        ss(2'h1, 2'h0, 8'h00, 8'h00, 8'h00);
        wr(0, 1, 16'h0100, 16'h0000, 16'h0000, 1'b0);
        rd(0, 1, 1'b1);
        ss(2'h3, 2'h0, 8'h00, 8'h00, 8'h00);
        rd(0, 1, 1'b0);
        wr(0, 3, 16'h0900, 16'h00ff, 16'hffff, 1'b1);
        ss(2'h3, 2'h0, 8'h00, 8'h0e, 8'h0a);
        rd(0, 3, 1'b0);
        ss(2'h3, 2'h0, 8'h00, 8'hbd, 8'h00);
        ss(2'h3, 2'h2, 8'h00, 8'h40, 8'h00);
        rd(0, 3, 1'b1);
        wr(0, 3, 16'h0900, 16'h0000, 16'hffff, 1'b0);
        ss(2'h3, 2'h0, 8'h00, 8'hbb, 8'h10);
        rd(0, 3, 1'b0);
        ss(2'h3, 2'h3, 8'h00, 8'h0d, 8'h00);
        rd(0, 3, 1'b0);
        wr(0, 3, 16'h1234, 16'h5678, 16'h9abc, 1'b0, UID + 8'h01);
        wr(0, 3, 16'h1234, 16'h5678, 16'h9abc, 1'b0, UID, 16'h0001);
        repeat (6) begin
            r = xs();
            s = int'(r[9:8]) % 3;
            n = 1 + int'(r[11:10]) % (3 - s);
            ss(r[1:0], r[3:2], r[15:8], r[23:16], r[31:24]);
            wr(s, n, 16'(xs()), 16'(xs()), 16'(xs()), r[4]);
            rd(s, n, r[5]);
        end
        print_verdict();
    end
endmodule
